// ===== bench/tcp_bench.sv
`timescale 1ns/1ns
`define CHK(g, e) begin \
  n_tests++; \
  if ((g) !== (e)) begin \
    mismatches++; \
    $display("[ERR] %0t got %h want %h", $time, (g), (e)); \
  end \
end
// Bench for the translation cache and its protection checks
module tcp_bench;
  import tcp_pkg::*;
  logic             sys_clk = 1'b0;
  logic             rst_n = 1'b0;
  logic             psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]       paddr = '0;
  logic [31:0]      pwdata = '0, prdata, acc_addr = '0, acc_paddr;
  logic             pready, pslverr, acc_done, acc_err;
  logic             acc_valid = 1'b0, acc_write = 1'b0, acc_super = 1'b0;
  logic             acc_alt_move = 1'b0, acc_alt_super = 1'b0;
  logic [1:0]       acc_cache_mode, walk_cache_mode, dly = '0;
  logic             acc_cachable, acc_copyback, acc_serialized;
  logic             walk_req, walk_super, walk_set_m, walk_done;
  logic [31:0]      walk_root, walk_addr, flush_addr = '0;
  logic [PPN_W-1:0] walk_ppn;
  logic             walk_fault, walk_wp, walk_s, walk_g, walk_m;
  logic             flush_req = 1'b0, flush_by_addr = 1'b0;
  logic             flush_nonglob = 1'b0, flush_super = 1'b0;
  logic             flush_done, irq, last_set_m, last_super, e, pg8k = 1'b0;
  int               n_walks, mismatches = 0, n_tests = 0;
  logic [31:0]      seed = 32'h2B483C17, sup_root, usr_root, rd, r_pa;
  logic [4:0]       r_res; // Error, cache mode and its decode

  tcp_top #(.N(4)) tcp_top_inst (.*);
  tcp_walk_model tcp_walk_model_inst (.*);

  // Free-running clock
  always #25 sys_clk = ~sys_clk;

  // Xorshift source
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Translated address from root and page size
  function automatic logic [31:0] exp_pa(logic [31:0] a, r, logic p8);
    logic [19:0] pn;
    pn = a[31:12] ^ r[31:12];
    return p8 ? {pn[19:1], a[12:0]} : {pn, a[11:0]};
  endfunction

  // One APB transfer; read data lands in rd, error in e
  task automatic apb(input logic w, input logic [7:0] a, input [31:0] d);
    int k;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    e  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    `CHK(k < 50, 1'b1)
    @(posedge sys_clk);
  endtask

  // Page size select through the control register
  task automatic pg(input logic v);
    pg8k = v;
    apb(1'b1, OFF_CTRL, {31'h0, v});
  endtask

  // Flush request held until answered
  task automatic flush(input logic by, ng, input logic [31:0] fa);
    int k;
    flush_req     <= 1'b1;
    flush_by_addr <= by;
    flush_nonglob <= ng;
    flush_addr    <= fa;
    flush_super   <= 1'b0;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (flush_done !== 1'b1 && k < 20);
    flush_req <= 1'b0;
    `CHK(k < 20, 1'b1)
    @(posedge sys_clk);
  endtask

  // Access, then compare error, search count, address and mode
  task automatic go(input logic [31:0] a, input logic w, s, am, as, ee,
                    input int dw);
    int   n0;
    int   k;
    logic p;
    n0 = n_walks;
    p  = am ? as : s;
    acc_valid     <= 1'b1;
    acc_addr      <= a;
    acc_write     <= w;
    acc_super     <= s;
    acc_alt_move  <= am;
    acc_alt_super <= as;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (acc_done !== 1'b1 && k < 100);
    r_res = {acc_err, acc_cache_mode, acc_cachable, acc_copyback};
    r_pa  = acc_paddr;
    e     = acc_serialized;
    acc_valid <= 1'b0;
    @(posedge sys_clk);
    `CHK(k < 100, 1'b1)
    `CHK(r_res[4], ee)
    if (dw >= 0) `CHK(n_walks - n0, dw)
    if (n_walks != n0) `CHK(last_super, p)
    if (!ee) begin
      `CHK(r_pa, exp_pa(a, p ? sup_root : usr_root, pg8k))
      `CHK(r_res[3:0], {a[20:19], ~a[20], a[20:19] == 2'b01})
      `CHK(e, a[20:19] == 2'b10)
    end
  endtask

  // Verdict and end of run
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Cuts a hang short
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    test_done();
  end

  // Main sequence
  initial begin : main
    logic [31:0] a, r;
    logic        s, am, as, p, ee;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    // Registers come up cleared; unmapped offset refused
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 8'(i * 4), '0);
      `CHK(rd, 32'h0)
    end
    apb(1'b0, 8'h14, '0);
    `CHK({e, rd}, {1'b1, 32'h0})
    sup_root = xs();
    usr_root = xs();
    apb(1'b1, OFF_SUP_ROOT, sup_root);
    apb(1'b1, OFF_USR_ROOT, usr_root);
    apb(1'b1, OFF_MASK, 32'h7);
    apb(1'b0, OFF_USR_ROOT, '0);
    `CHK(rd, usr_root)
    // Random pages: protection, roots, page size, modified update
    repeat (40) begin
      a = xs() & 32'hFFDF_FFFF;
      r = xs();
      dly <= r[1:0];
      {s, am, as} = r[4:2];
      p  = am ? as : s;
      ee = !p && a[17];
      pg(r[5]);
      flush(1'b0, 1'b0, '0);
      go(a, 1'b0, s, am, as, ee, 1);
      ee = ee | a[16] | a[15];
      go(a, 1'b1, s, am, as, ee, ee ? -1 : 1);
      if (!ee) `CHK(last_set_m, 1'b1)
      if (!ee) go(a, 1'b1, s, am, as, 1'b0, 0);
    end
    // Privilege bit keeps separate entries for one page
    a = 32'h1200_3000;
    pg(1'b0);
    flush(1'b0, 1'b0, '0);
    go(a, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1);
    go(a, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1);
    go(a, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 0);
    // Neighbour page misses at 4K, hits at 8K
    go(a ^ 32'h1000, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1);
    pg(1'b1);
    flush(1'b0, 1'b0, '0);
    go(a, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1);
    go(a ^ 32'h1000, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 0);
    pg(1'b0);
    // Global entry outlives nonglobal flush only
    a = a | 32'h0004_0000;
    flush(1'b0, 1'b0, '0);
    go(a, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1);
    flush(1'b0, 1'b1, '0);
    go(a, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 0);
    flush(1'b1, 1'b0, a);
    go(a, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1);
    // Invalid descriptor reports an error
    go(a | 32'h0020_0000, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1);
    // Equal roots give one mapping for both modes
    usr_root = sup_root;
    apb(1'b1, OFF_USR_ROOT, usr_root);
    go(a, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1);
    go(a, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 0);
    flush(1'b0, 1'b0, '0);
    go(a, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1);
    // Sticky status, mask gating, write one to clear
    repeat (2) @(posedge sys_clk);
    `CHK(irq, 1'b1)
    apb(1'b0, OFF_STAT, '0);
    `CHK(rd, 32'h7)
    apb(1'b1, OFF_MASK, '0);
    repeat (2) @(posedge sys_clk);
    `CHK(irq, 1'b0)
    apb(1'b1, OFF_STAT, 32'h7);
    apb(1'b0, OFF_STAT, '0);
    `CHK(rd, 32'h0)
    test_done();
  end
endmodule // tcp_bench

// ===== bench/tcp_walk_model.sv
`timescale 1ns/1ns
// Table search walker stand-in: descriptor bits come from the address
module tcp_walk_model (
  input  wire logic                     sys_clk,
  input  wire logic                     rst_n,
  input  wire logic                     walk_req,
  input  wire logic [31:0]              walk_root,
  input  wire logic [31:0]              walk_addr,
  input  wire logic                     walk_super,
  input  wire logic                     walk_set_m,
  input  wire logic [1:0]               dly,        // Answer delay
  output logic                          walk_done,
  output logic                          walk_fault,
  output logic [tcp_pkg::PPN_W-1:0]     walk_ppn,
  output logic                          walk_wp,
  output logic                          walk_s,
  output logic                          walk_g,
  output logic                          walk_m,
  output logic [1:0]                    walk_cache_mode,
  output int                            n_walks,    // Finished searches
  output logic                          last_set_m, // Set-M of last one
  output logic                          last_super  // Space of last one
);
  import tcp_pkg::*;
  logic [1:0]  cnt;  // Cycles waited so far
  logic [26:0] flds; // Descriptor fields in port order
  assign {walk_fault, walk_ppn, walk_wp, walk_s, walk_g, walk_m,
          walk_cache_mode} = flds;
  // Answer after dly cycles; idle fields change every cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt        <= '0;
      flds       <= '0;
      walk_done  <= 1'b0;
      n_walks    <= 0;
      last_set_m <= 1'b0;
      last_super <= 1'b0;
    end else if (walk_done) begin
      walk_done  <= 1'b0;
      cnt        <= '0;
      n_walks    <= n_walks + 1;
      last_set_m <= walk_set_m;
      last_super <= walk_super;
      flds       <= ~flds;
    end else if (walk_req && cnt >= dly) begin
      walk_done <= 1'b1;
      flds <= {walk_addr[21],                        // Invalid descriptor
               walk_addr[31:12] ^ walk_root[31:12],  // Page frame
               walk_addr[16] | walk_addr[15],        // W of all levels
               walk_addr[17], walk_addr[18],         // S and G bits
               1'b0, walk_addr[20:19]};              // M clear, cache mode
    end else begin
      cnt  <= walk_req ? cnt + 2'h1 : 2'h0;
      flds <= ~flds;
    end
  end
endmodule // tcp_walk_model

// ===== verilog/tcp_match.sv
`timescale 1ns/1ns
// Per-entry tag compare for lookups and flush selection
module tcp_match #(parameter int N = 4) (
  tcp_match_if.matcher mi
);
  import tcp_pkg::*;
  logic [TAG_W-1:0] cmp_mask; // Ignores low tag bit on 8K pages

  // Page size picks the compared tag bits
  assign cmp_mask = mi.pg8k ? TAG_MASK_8K : TAG_MASK_4K;

  // One comparator pair per entry
  for (genvar i = 0; i < N; i++) begin : g_ent
    logic tag_eq;  // Lookup tag equal
    logic ftag_eq; // Flush tag equal
    assign tag_eq = ((mi.ent[i].tag ^ mi.addr[31:PG4K_LSB])
                     & cmp_mask) == '0;
    assign ftag_eq = ((mi.ent[i].tag ^ mi.faddr[31:PG4K_LSB])
                      & cmp_mask) == '0;
    // Hit needs valid, tag and privilege match
    assign mi.hit[i] = mi.ent[i].valid && tag_eq
                       && (mi.ent[i].priv == mi.priv);
    // Global entries survive nonglobal flushes
    assign mi.fsel[i] = mi.ent[i].valid
                        && (!mi.by_addr
                            || (ftag_eq && mi.ent[i].priv == mi.fpriv))
                        && !(mi.nonglob && mi.ent[i].glob);
  end
endmodule // tcp_match

// ===== verilog/tcp_match_if.sv
`timescale 1ns/1ns
// Entry array and lookup keys towards the tag matcher
interface tcp_match_if #(parameter int N = 4);
  import tcp_pkg::*;
  tcp_entry_t [N-1:0] ent;     // All entries
  logic [31:0]        addr;    // Lookup address
  logic               priv;    // Lookup privilege
  logic               pg8k;    // Page size select
  logic [31:0]        faddr;   // Flush address
  logic               fpriv;   // Flush privilege
  logic               by_addr; // Flush selects by address
  logic               nonglob; // Flush spares global entries
  logic [N-1:0]       hit;     // Lookup hit per entry
  logic [N-1:0]       fsel;    // Flush selection per entry
  modport owner (output ent, addr, priv, pg8k, faddr, fpriv, by_addr,
                 output nonglob, input hit, fsel);
  modport matcher (input ent, addr, priv, pg8k, faddr, fpriv, by_addr,
                   input nonglob, output hit, fsel);
endinterface

// ===== verilog/tcp_pkg.sv
package tcp_pkg;
  // Register byte offsets on the APB port
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_SUP_ROOT = 8'h04;
  localparam logic [7:0] OFF_USR_ROOT = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0C;
  localparam logic [7:0] OFF_MASK = 8'h10;
  // Control bit positions
  localparam int CTRL_PG8K = 0;
  localparam int CTRL_BUSY = 1;
  // Status and mask bit positions
  localparam int STAT_ERR   = 0;
  localparam int STAT_MUPD  = 1;
  localparam int STAT_FLUSH = 2;
  localparam int STAT_W     = 3;
  // Cache mode field codes
  localparam logic [1:0] MODE_WT  = 2'h0;
  localparam logic [1:0] MODE_CB  = 2'h1;
  localparam logic [1:0] MODE_NCS = 2'h2;
  localparam logic [1:0] MODE_NC  = 2'h3;
  // Page geometry
  localparam int PG4K_LSB = 12;
  localparam int PG8K_LSB = 13;
  localparam int TAG_W    = 20;
  localparam int PPN_W    = 20;
  localparam logic [19:0] TAG_MASK_4K = 20'hFFFFF;
  localparam logic [19:0] TAG_MASK_8K = 20'hFFFFE;
  // Lookup state machine
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOOK = 2'b01,
    ST_WALK = 2'b10,
    ST_DONE = 2'b11
  } tcp_state_t;
  // One translation cache entry
  typedef struct packed {
    logic             valid;
    logic [TAG_W-1:0] tag;
    logic             priv;
    logic             glob;
    logic [1:0]       cache_mode;
    logic             m;
    logic             wp;
    logic             s;
    logic [PPN_W-1:0] ppn;
  } tcp_entry_t;
endpackage

// ===== verilog/tcp_top.sv
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/1ns
// Overview of operation
// - Separate supervisor and user translation tables kept
// - Write-protect bit blocks writes through descriptor
// - Supervisor-only bit restricts page to supervisor
// - Supervisor uses supervisor root; alternate alternate_space_move excepted
// - User walk hitting supervisor-only creates flagged entry
// - User retry on supervisor-only entry faults
// - Equal root pointers give one common mapping
// - Entry holds physical page, attributes, tag
// - Cache mode decodes write-through, copyback, noncachable
// - Entry privilege bit records creating access mode
// - Global entries survive nonglobal flushes
// - Tag compares bits 31-12, or 31-13
// - Valid write sets entry modified bit
// - Clear modified bit forces update walk first
module tcp_top #(
  parameter int N = 4
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Logical access from the integer unit
  input  wire logic        acc_valid,
  input  wire logic [31:0] acc_addr,
  input  wire logic        acc_write,
  input  wire logic        acc_super,
  input  wire logic        acc_alt_move,
  input  wire logic        acc_alt_super,
  output logic             acc_done,
  output logic             acc_err,
  output logic [31:0]      acc_paddr,
  output logic [1:0]       acc_cache_mode,
  output logic             acc_cachable,
  output logic             acc_copyback,
  output logic             acc_serialized,
  // Table search walker
  output logic             walk_req,
  output logic [31:0]      walk_root,
  output logic [31:0]      walk_addr,
  output logic             walk_super,
  output logic             walk_set_m,
  input  wire logic        walk_done,
  input  wire logic        walk_fault,
  input  wire logic [tcp_pkg::PPN_W-1:0] walk_ppn,
  input  wire logic        walk_wp,
  input  wire logic        walk_s,
  input  wire logic        walk_g,
  input  wire logic        walk_m,
  input  wire logic [1:0]  walk_cache_mode,
  // Translation flush operation
  input  wire logic        flush_req,
  input  wire logic        flush_by_addr,
  input  wire logic        flush_nonglob,
  input  wire logic [31:0] flush_addr,
  input  wire logic        flush_super,
  output logic             flush_done,
  // Interrupt
  output logic             irq
);
  import tcp_pkg::*;
  localparam int IW = (N > 1) ? $clog2(N) : 1;

  // All state of the block
  typedef struct packed {
    tcp_state_t         st;
    tcp_entry_t [N-1:0] ent;
    logic [31:0]        req_addr;
    logic               req_write;
    logic               req_priv;
    logic [IW-1:0]      victim;
    logic [31:0]        sup_root;
    logic [31:0]        usr_root;
    logic               pg8k;
    logic [STAT_W-1:0]  status;
    logic [STAT_W-1:0]  mask;
    logic               irq;
    logic               pready;
    logic [31:0]        prdata;
    logic               pslverr;
    logic               acc_done;
    logic               acc_err;
    logic [31:0]        acc_paddr;
    logic [1:0]         acc_cache_mode;
    logic               acc_cachable;
    logic               acc_copyback;
    logic               acc_serialized;
    logic               walk_req;
    logic [31:0]        walk_root;
    logic               walk_set_m;
    logic               flush_done;
  } tcp_regs_t;

  tcp_regs_t         q;       // Registered state
  tcp_regs_t         next_q;  // Next state
  tcp_entry_t        he;      // Hit entry
  logic [IW-1:0]     hidx;    // Hit index
  logic              hany;    // Any hit
  logic [IW-1:0]     slot;    // Fill slot
  logic [STAT_W-1:0] ev;      // Events this cycle
  logic [STAT_W-1:0] w1c;     // Status bits cleared by software
  logic              apb_wr;  // Write completes this edge
  logic              sfault;  // User access on supervisor page

  tcp_match_if #(.N(N)) mi ();

  // Tag matcher per entry
  tcp_match #(.N(N)) u_match (
    .mi (mi)
  );

  // Lookup keys come from the latched request; flush keys come straight from the flush ports
  assign mi.ent     = q.ent;
  assign mi.addr    = q.req_addr;
  assign mi.priv    = q.req_priv;
  assign mi.pg8k    = q.pg8k;
  assign mi.faddr   = flush_addr;
  assign mi.fpriv   = flush_super;
  assign mi.by_addr = flush_by_addr;
  assign mi.nonglob = flush_nonglob;

  // Priority encode the hit vector
  always_comb begin
    hidx = '0;
    hany = 1'b0;
    for (int i = N - 1; i >= 0; i--) begin
      if (mi.hit[i]) begin
        hidx = IW'(i);
        hany = 1'b1;
      end
    end
  end

  assign he     = q.ent[hidx];
  assign slot   = hany ? hidx : q.victim;
  assign sfault = he.s && !q.req_priv;
  assign apb_wr = psel && penable && q.pready && pwrite;

  // Next-state logic of the whole block
  always_comb begin
    next_q            = q;
    ev                = '0;
    w1c               = '0;
    next_q.pready     = 1'b0;
    next_q.pslverr    = 1'b0;
    next_q.acc_done   = 1'b0;
    next_q.acc_err    = 1'b0;
    next_q.flush_done = 1'b0;
    // APB read data and answer, one wait state
    if (psel && penable && !q.pready) begin
      next_q.pready = 1'b1;
      next_q.prdata = '0;
      unique case (paddr)
        OFF_CTRL: begin
          next_q.prdata[CTRL_PG8K] = q.pg8k;
          next_q.prdata[CTRL_BUSY] = q.st != ST_IDLE;
        end
        OFF_SUP_ROOT: next_q.prdata = q.sup_root;
        OFF_USR_ROOT: next_q.prdata = q.usr_root;
        OFF_STAT: next_q.prdata[STAT_W-1:0] = q.status;
        OFF_MASK: next_q.prdata[STAT_W-1:0] = q.mask;
        default:  next_q.pslverr = 1'b1; // Unmapped address
      endcase
    end
    // APB writes take effect at the completing edge
    if (apb_wr) begin
      unique case (paddr)
        OFF_CTRL: next_q.pg8k = pwdata[CTRL_PG8K];
        OFF_SUP_ROOT: next_q.sup_root = pwdata;
        OFF_USR_ROOT: next_q.usr_root = pwdata;
        OFF_STAT: w1c = pwdata[STAT_W-1:0];
        OFF_MASK: next_q.mask = pwdata[STAT_W-1:0];
        default: ;
      endcase
    end
    // Lookup, protection and table search sequencing
    unique case (q.st)
      ST_IDLE: begin
        if (flush_req) begin
          // Flush wins over a pending access
          for (int i = 0; i < N; i++) begin
            if (mi.fsel[i]) begin
              next_q.ent[i].valid = 1'b0;
            end
          end
          next_q.flush_done = 1'b1;
          ev[STAT_FLUSH]    = 1'b1;
        end else if (acc_valid) begin
          next_q.req_addr  = acc_addr;
          next_q.req_write = acc_write;
          // Alternate alternate_space_move name their own space
          next_q.req_priv  = acc_alt_move ? acc_alt_super
                                          : acc_super;
          next_q.st        = ST_LOOK;
        end
      end
      ST_LOOK: begin
        if (hany && sfault) begin
          // User access to supervisor-only page
          next_q.acc_done = 1'b1;
          next_q.acc_err  = 1'b1;
          ev[STAT_ERR]    = 1'b1;
          next_q.st       = ST_DONE;
        end else if (hany && q.req_write && he.wp) begin
          // Write through protected descriptor
          next_q.acc_done = 1'b1;
          next_q.acc_err  = 1'b1;
          ev[STAT_ERR]    = 1'b1;
          next_q.st       = ST_DONE;
        end else if (hany && !(q.req_write && !he.m)) begin
          // Translation complete
          next_q.acc_done  = 1'b1;
          next_q.acc_cache_mode = he.cache_mode;
          next_q.acc_cachable   = he.cache_mode == MODE_WT
                                  || he.cache_mode == MODE_CB;
          next_q.acc_copyback   = he.cache_mode == MODE_CB;
          next_q.acc_serialized = he.cache_mode == MODE_NCS;
          if (q.pg8k) begin
            next_q.acc_paddr = {he.ppn[PPN_W-1:1],
                                q.req_addr[PG8K_LSB-1:0]};
          end else begin
            next_q.acc_paddr = {he.ppn, q.req_addr[PG4K_LSB-1:0]};
          end
          if (q.req_write) begin
            next_q.ent[hidx].m = 1'b1;
          end
          next_q.st = ST_DONE;
        end else begin
          // Miss, or write with clear modified bit: hold and search
          next_q.walk_req   = 1'b1;
          next_q.walk_set_m = hany;
          ev[STAT_MUPD]     = hany;
          // Root pointer picked by privilege
          next_q.walk_root  = q.req_priv ? q.sup_root
                                         : q.usr_root;
          next_q.st         = ST_WALK;
        end
      end
      ST_WALK: begin
        if (walk_done) begin
          next_q.walk_req = 1'b0;
          if (walk_fault) begin
            next_q.acc_done = 1'b1;
            next_q.acc_err  = 1'b1;
            ev[STAT_ERR]    = 1'b1;
            next_q.st       = ST_DONE;
          end else begin
            // Fresh descriptor overwrites the slot, then retry
            next_q.ent[slot].valid = 1'b1;
            next_q.ent[slot].tag   = q.req_addr[31:PG4K_LSB];
            next_q.ent[slot].priv  = q.req_priv;
            next_q.ent[slot].glob  = walk_g;
            next_q.ent[slot].cache_mode = walk_cache_mode;
            next_q.ent[slot].m     = walk_m || q.walk_set_m;
            next_q.ent[slot].wp    = walk_wp;
            next_q.ent[slot].s     = walk_s;
            next_q.ent[slot].ppn   = walk_ppn;
            if (!hany) begin
              next_q.victim = q.victim + 1'b1;
            end
            next_q.st = ST_LOOK;
          end
        end
      end
      ST_DONE: next_q.st = ST_IDLE;
    endcase
    // Sticky status, set wins over clear
    next_q.status = (q.status & ~w1c) | ev;
    next_q.irq    = |(next_q.status & next_q.mask);
  end

  // State register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  // Outputs straight from flops
  assign pready         = q.pready;
  assign prdata         = q.prdata;
  assign pslverr        = q.pslverr;
  assign acc_done       = q.acc_done;
  assign acc_err        = q.acc_err;
  assign acc_paddr      = q.acc_paddr;
  assign acc_cache_mode = q.acc_cache_mode;
  assign acc_cachable   = q.acc_cachable;
  assign acc_copyback   = q.acc_copyback;
  assign acc_serialized = q.acc_serialized;
  assign walk_req       = q.walk_req;
  assign walk_root      = q.walk_root;
  assign walk_addr      = q.req_addr;
  assign walk_super     = q.req_priv;
  assign walk_set_m     = q.walk_set_m;
  assign flush_done     = q.flush_done;
  assign irq            = q.irq;

  // Checks on the block's own behaviour
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  root_select_a: assert property ($rose(q.walk_req) |->
    q.walk_root == (q.req_priv ? q.sup_root : q.usr_root))
    else $error("walk root does not follow privilege");
  common_map_a: assert property ($rose(q.walk_req)
    && q.sup_root == q.usr_root |-> q.walk_root == q.usr_root)
    else $error("equal roots not common");
  super_only_a: assert property (q.st == ST_LOOK && hany && sfault
    |=> q.acc_done && q.acc_err && q.st == ST_DONE)
    else $error("user access on supervisor page not faulted");
  write_prot_a: assert property (q.st == ST_LOOK && hany
    && !sfault && q.req_write && he.wp |=> q.acc_err)
    else $error("protected write not faulted");
  mod_walk_a: assert property (q.st == ST_LOOK && hany
    && !sfault && q.req_write && !he.wp && !he.m |=>
    q.walk_req && q.walk_set_m && !q.acc_done)
    else $error("clear modified bit did not force search");
  fill_hit_a: assert property (q.st == ST_WALK && walk_done
    && !walk_fault |=> hany)
    else $error("filled entry does not hit on retry");
  s_fill_a: assert property (q.st == ST_WALK && walk_done
    && !walk_fault && walk_s && !q.req_priv |=> ##1 q.acc_done && q.acc_err)
    else $error("supervisor-only fill not faulted on retry");
  glob_keep_a: assert property (q.st == ST_IDLE && flush_req
    && flush_nonglob && q.ent[0].valid && q.ent[0].glob
    |=> q.ent[0].valid)
    else $error("global entry flushed");
  mod_set_a: assert property (q.acc_done && !q.acc_err
    && q.req_write |-> hany && q.ent[hidx].m)
    else $error("write done without modified bit");
  mode_decode_a: assert property (q.acc_done && !q.acc_err |->
    q.acc_cachable == !q.acc_cache_mode[1]
    && q.acc_serialized == (q.acc_cache_mode == MODE_NCS))
    else $error("cache mode decode wrong");
  page_offs_a: assert property (q.acc_done && !q.acc_err && q.pg8k
    |-> q.acc_paddr[PG8K_LSB-1:0] == q.req_addr[PG8K_LSB-1:0])
    else $error("8K page offset not passed");

  err_seen_c: cover property (q.acc_done && q.acc_err);
  mupd_seen_c: cover property ($rose(q.walk_req) && q.walk_set_m);
  flush_seen_c: cover property (q.flush_done);
  s_fill_c: cover property (q.st == ST_WALK && walk_done && walk_s
    && !q.req_priv);
endmodule // tcp_top
